// ==== epc_core.v ====
// What this block does
// - hardware latches encoder count on trigger
// - capture on any clock, not servo boundary
// - trigger from index, flag, or both
// - 4-bit code picks inputs and levels
// - flag choice: home, plus, minus, user
// - older variant uses own channel flags only
// - newer variant picks flag source channel
// - flag source resets to own channel
// - fractional timer estimate captured alongside
// - monitor checks trigger each interrupt tick
// - monitor converts capture, stores motor position
// - monitor watches pointer-selected status bit
// - rescale with right, left shift, rounding
// - monitor clears request when done
// - monitor never touches commanded motion
// - captured bit set; count read clears, re-arms
// - gated index bit set with captured bit
// - older variant retriggers on level after read
// - newer variant needs fresh edge to retrigger
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "epc_defs.vh"

module epc_core #(
    parameter NCH = 4,
    parameter CW = 24,
    parameter FW = 12,
    parameter NEW_VARIANT = 1
) (
    input wire mclk,
    input wire nrst,
    input wire [5:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [31:0] rdata_r,
    input wire [NCH*CW-1:0] enc_count,
    input wire [NCH*FW-1:0] enc_frac,
    input wire [NCH-1:0] index_in,
    input wire [NCH*4-1:0] flag_in,
    input wire real_time_interrupt_tick,
    output reg monitor_request_r,
    output reg [31:0] captured_motor_position_r
);

// ======================================================================
// monitor states
localparam MON_IDLE = 1'b0;
localparam MON_CONV = 1'b1;

// ======================================================================
// helpers
function is_chan_reg;
    input [5:0] a;
    input [2:0] r;
    begin
        is_chan_reg = ~a[`EPC_GLOBAL_BIT] & (a[2:0] == r);
    end
endfunction

function pick_flag;
    input [NCH*4-1:0] flags;
    input [1:0] src;
    input [1:0] choice;
    begin
        // flag sets are grouped four to a channel
        pick_flag = flags[{src, choice}];
    end
endfunction

// ======================================================================
// channel state
// flat copy of every channel's control word for the read port
wire [NCH*`EPC_CTRL_W-1:0] ctrl_flat;
wire [NCH*CW-1:0] cap_count;
wire [NCH*FW-1:0] cap_frac;
wire [NCH*2-1:0] cap_pair;
wire [NCH-1:0] bus_rearm;
wire [NCH-1:0] mon_rearm;

// ======================================================================
// monitor state
reg mon_state_r;
reg [1:0] trigger_word_pointer_r;
reg [1:0] trigger_bit_index_r;
reg [4:0] raw_shift_right_r;
reg [4:0] raw_shift_left_r;
reg raw_rounding_r;
reg [31:0] motor_offset_r;
reg [CW+FW-1:0] mon_raw_r;

wire [1:0] watched_pair = cap_pair[trigger_word_pointer_r*2 +: 2];
wire [3:0] watched_word = {2'b00, watched_pair};
wire watched_bit = watched_word[trigger_bit_index_r];
wire mon_hit = (mon_state_r == MON_IDLE) & monitor_request_r & real_time_interrupt_tick & watched_bit;

// ======================================================================
// channels
genvar gi;
generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
        localparam [31:0] CH_ID = gi;
        reg [`EPC_CTRL_W-1:0] ctrl_r;
        wire [1:0] src;
        wire flag_sel;
        wire frac_on;
        assign ctrl_flat[gi*`EPC_CTRL_W +: `EPC_CTRL_W] = ctrl_r;
        // older part has no cross-channel routing
        assign src = (NEW_VARIANT != 0) ? ctrl_r[`EPC_SOURCE_MSB:`EPC_SOURCE_LSB] : CH_ID[1:0];
        assign flag_sel = pick_flag(flag_in, src, ctrl_r[`EPC_CHOICE_MSB:`EPC_CHOICE_LSB]);
        // newer part always carries the timer fraction
        assign frac_on = (NEW_VARIANT != 0) | ctrl_r[`EPC_FRAC_EN_BIT];
        assign bus_rearm[gi] = rd_stb & is_chan_reg(addr, `EPC_CH_COUNT) & (addr[4:3] == CH_ID[1:0]);
        assign mon_rearm[gi] = mon_hit & (trigger_word_pointer_r == CH_ID[1:0]);

        always @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                ctrl_r <= {1'b0, 1'b0, CH_ID[1:0], `EPC_CHOICE_RST, `EPC_CTRL_RST};
            end else if (wr_stb & is_chan_reg(addr, `EPC_CH_CTRL) & (addr[4:3] == CH_ID[1:0])) begin
                ctrl_r <= wdata[`EPC_CTRL_W-1:0];
            end
        end

        epc_chan #(
            .CW(CW),
            .FW(FW),
            .EDGE_TRIG(NEW_VARIANT)
        ) u_chan (
            .mclk(mclk),
            .nrst(nrst),
            .enc_count(enc_count[gi*CW +: CW]),
            .enc_frac(enc_frac[gi*FW +: FW]),
            .index_in(index_in[gi]),
            .flag_in(flag_sel),
            .trigger_select_code(ctrl_r[`EPC_TRIG_MSB:`EPC_TRIG_LSB]),
            .index_gating_select(ctrl_r[`EPC_GATING_BIT]),
            .frac_en(frac_on),
            .rearm(bus_rearm[gi] | mon_rearm[gi]),
            .cap_count_r(cap_count[gi*CW +: CW]),
            .cap_frac_r(cap_frac[gi*FW +: FW]),
            .capture_status_pair_r(cap_pair[gi*2 +: 2])
        );
    end
endgenerate

// ======================================================================
// rescale: left shift, then rounded right shift
wire [47:0] raw_wide = {{(48-CW-FW){1'b0}}, mon_raw_r};
wire [47:0] shl = raw_wide << raw_shift_left_r;
wire [47:0] half = (raw_rounding_r && (raw_shift_right_r != 5'h0)) ? (48'h1 << (raw_shift_right_r - 5'h1)) :
    48'h0;
wire [47:0] scaled = (shl + half) >> raw_shift_right_r;
wire [31:0] motor_pos = scaled[31:0] - motor_offset_r;

// ======================================================================
// monitor sequencer; it only writes its own result registers,
// so commanded motion has no path from here
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        mon_state_r <= MON_IDLE;
        mon_raw_r <= {(CW+FW){1'b0}};
        captured_motor_position_r <= `EPC_MON_RST;
    end else begin
        case (mon_state_r)
            MON_IDLE: begin
                if (mon_hit) begin
                    // whole count and fraction taken before the re-arm lands
                    mon_raw_r <= {cap_count[trigger_word_pointer_r*CW +: CW],
                        cap_frac[trigger_word_pointer_r*FW +: FW]};
                    mon_state_r <= MON_CONV;
                end
            end
            MON_CONV: begin
                captured_motor_position_r <= motor_pos;
                mon_state_r <= MON_IDLE;
            end
            default: begin
                mon_state_r <= MON_IDLE;
            end
        endcase
    end
end

// ======================================================================
// monitor request: a software write in the finishing cycle wins,
// so a fresh request is never swallowed by the completion
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        monitor_request_r <= 1'b0;
    end else if (wr_stb && (addr == `EPC_MON_CTRL)) begin
        monitor_request_r <= wdata[`EPC_REQ_BIT];
    end else if (mon_state_r == MON_CONV) begin
        monitor_request_r <= 1'b0;
    end
end

// ======================================================================
// monitor configuration
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        trigger_word_pointer_r <= 2'h0;
        trigger_bit_index_r <= 2'h0;
        raw_shift_right_r <= 5'h0;
        raw_shift_left_r <= 5'h0;
        raw_rounding_r <= 1'b0;
        motor_offset_r <= `EPC_MON_RST;
    end else if (wr_stb) begin
        if (addr == `EPC_MON_SEL) begin
            trigger_word_pointer_r <= wdata[`EPC_PTR_MSB:`EPC_PTR_LSB];
            trigger_bit_index_r <= wdata[`EPC_BITIDX_MSB:`EPC_BITIDX_LSB];
        end else if (addr == `EPC_MON_SCALE) begin
            raw_shift_right_r <= wdata[`EPC_RSH_MSB:`EPC_RSH_LSB];
            raw_shift_left_r <= wdata[`EPC_LSH_MSB:`EPC_LSH_LSB];
            raw_rounding_r <= wdata[`EPC_RND_BIT];
        end else if (addr == `EPC_MON_OFFSET) begin
            motor_offset_r <= wdata;
        end
    end
end

// ======================================================================
// read port; unmapped reads return zero
reg [31:0] rd_val;
always @* begin
    rd_val = 32'h0;
    if (addr[`EPC_GLOBAL_BIT] == 1'b0) begin
        if (is_chan_reg(addr, `EPC_CH_CTRL)) begin
            rd_val = {{(32-`EPC_CTRL_W){1'b0}}, ctrl_flat[addr[4:3]*`EPC_CTRL_W +: `EPC_CTRL_W]};
        end else if (is_chan_reg(addr, `EPC_CH_STATUS)) begin
            rd_val = {30'h0, cap_pair[addr[4:3]*2 +: 2]};
        end else if (is_chan_reg(addr, `EPC_CH_COUNT)) begin
            rd_val = {{(32-CW){1'b0}}, cap_count[addr[4:3]*CW +: CW]};
        end else if (is_chan_reg(addr, `EPC_CH_FRAC)) begin
            rd_val = {{(32-FW){1'b0}}, cap_frac[addr[4:3]*FW +: FW]};
        end
    end else if (addr == `EPC_MON_CTRL) begin
        rd_val = {31'h0, monitor_request_r};
    end else if (addr == `EPC_MON_SEL) begin
        rd_val = {26'h0, trigger_bit_index_r, 2'h0, trigger_word_pointer_r};
    end else if (addr == `EPC_MON_SCALE) begin
        rd_val = {15'h0, raw_rounding_r, 3'h0, raw_shift_left_r, 3'h0, raw_shift_right_r};
    end else if (addr == `EPC_MON_OFFSET) begin
        rd_val = motor_offset_r;
    end else if (addr == `EPC_MON_RESULT) begin
        rd_val = captured_motor_position_r;
    end
end

// data valid only in the cycle after the strobe
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        rdata_r <= 32'h0;
    end else if (rd_stb) begin
        rdata_r <= rd_val;
    end else begin
        rdata_r <= 32'h0;
    end
end

endmodule
`default_nettype wire

// ==== epc_defs.vh ====
`ifndef EPC_DEFS_VH
`define EPC_DEFS_VH

// ======================================================================
// register map: plain port, word index on addr
// per channel block: channel number in addr[4:3], register in addr[2:0]
`define EPC_CH_CTRL 3'h0
`define EPC_CH_STATUS 3'h1
`define EPC_CH_COUNT 3'h2
`define EPC_CH_FRAC 3'h3
`define EPC_GLOBAL_BIT 5
`define EPC_MON_CTRL 6'h20
`define EPC_MON_SEL 6'h21
`define EPC_MON_SCALE 6'h22
`define EPC_MON_OFFSET 6'h23
`define EPC_MON_RESULT 6'h24

// ======================================================================
// channel control fields
`define EPC_TRIG_LSB 0
`define EPC_TRIG_MSB 3
`define EPC_USE_INDEX 0
`define EPC_INDEX_LEVEL 1
`define EPC_USE_FLAG 2
`define EPC_FLAG_LEVEL 3
`define EPC_CHOICE_LSB 4
`define EPC_CHOICE_MSB 5
`define EPC_SOURCE_LSB 6
`define EPC_SOURCE_MSB 7
`define EPC_GATING_BIT 8
`define EPC_FRAC_EN_BIT 9
`define EPC_CTRL_W 10

// ======================================================================
// status pair fields
`define EPC_ST_INDEX 0
`define EPC_ST_CAPTURED 1

// ======================================================================
// monitor fields
`define EPC_REQ_BIT 0
`define EPC_PTR_LSB 0
`define EPC_PTR_MSB 1
`define EPC_BITIDX_LSB 4
`define EPC_BITIDX_MSB 5
`define EPC_RSH_LSB 0
`define EPC_RSH_MSB 4
`define EPC_LSH_LSB 8
`define EPC_LSH_MSB 12
`define EPC_RND_BIT 16

// ======================================================================
// reset values
`define EPC_CTRL_RST 4'h0
`define EPC_CHOICE_RST 2'h0
`define EPC_MON_RST 32'h0

`endif

// ==== epc_chan.v ====
`timescale 1ns/1ps
`default_nettype none
`include "epc_defs.vh"

module epc_chan #(
    parameter CW = 24,
    parameter FW = 12,
    parameter EDGE_TRIG = 1
) (
    input wire mclk,
    input wire nrst,
    input wire [CW-1:0] enc_count,
    input wire [FW-1:0] enc_frac,
    input wire index_in,
    input wire flag_in,
    input wire [3:0] trigger_select_code,
    input wire index_gating_select,
    input wire frac_en,
    input wire rearm,
    output reg [CW-1:0] cap_count_r,
    output reg [FW-1:0] cap_frac_r,
    output reg [1:0] capture_status_pair_r
);

// ======================================================================
// trigger condition
wire use_idx = trigger_select_code[`EPC_USE_INDEX];
wire use_flg = trigger_select_code[`EPC_USE_FLAG];
wire idx_ok = ~use_idx | (index_in == trigger_select_code[`EPC_INDEX_LEVEL]);
wire flg_ok = ~use_flg | (flag_in == trigger_select_code[`EPC_FLAG_LEVEL]);
wire hit = (use_idx | use_flg) & idx_ok & flg_ok;
reg hit_prev_r;
wire armed = ~capture_status_pair_r[`EPC_ST_CAPTURED];
// edge mode needs the condition to leave and come back after re-arm
wire fire = armed & hit & ((EDGE_TRIG != 0) ? ~hit_prev_r : 1'b1);

// ======================================================================
// latch; no servo-cycle gating, any clock edge captures
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        hit_prev_r <= 1'b0;
        cap_count_r <= {CW{1'b0}};
        cap_frac_r <= {FW{1'b0}};
        capture_status_pair_r <= 2'h0;
    end else begin
        hit_prev_r <= hit;
        if (fire) begin
            // value and status move together
            cap_count_r <= enc_count;
            cap_frac_r <= frac_en ? enc_frac : {FW{1'b0}};
            capture_status_pair_r[`EPC_ST_CAPTURED] <= 1'b1;
            capture_status_pair_r[`EPC_ST_INDEX] <= use_idx & index_gating_select;
        end else if (rearm) begin
            capture_status_pair_r <= 2'h0;
        end
    end
end

endmodule
`default_nettype wire

// ==== epc_core_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================
// port checker for the capture core
module epc_core_chk #(
    parameter CW = 24
) (
    input wire mclk,
    input wire nrst,
    input wire [5:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [31:0] rdata_r,
    input wire real_time_interrupt_tick,
    input wire monitor_request_r,
    input wire [31:0] captured_motor_position_r
);
    // saturating age of last tick, keeps long idle stretches cheap
    reg [2:0] since_tick_r;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) since_tick_r <= 3'h7;
        else if (real_time_interrupt_tick) since_tick_r <= 3'h0;
        else if (since_tick_r != 3'h7) since_tick_r <= since_tick_r + 3'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_read_idle: assert property (!$past(rd_stb) |-> rdata_r == 32'h0) else $error("read data not cleared");
    a_req_set: assert property (wr_stb && addr == 6'h20 && wdata[0] |=> monitor_request_r) else $error("request not set");
    a_req_drop: assert property (wr_stb && addr == 6'h20 && !wdata[0] |=> !monitor_request_r) else $error("request stuck");
    a_req_done: assert property ($fell(monitor_request_r) && !$past(wr_stb) |-> since_tick_r <= 3'h3) else $error("clear without tick");
    a_result_cause: assert property ($changed(captured_motor_position_r) |-> $past(monitor_request_r) && since_tick_r <= 3'h3) else $error("stray result");
    a_result_done: assert property ($changed(captured_motor_position_r) && !$past(wr_stb) |-> !monitor_request_r) else $error("result without clear");
    a_unmapped_zero: assert property (rd_stb && (addr > 6'h24 || (!addr[5] && addr[2])) |=> rdata_r == 32'h0) else $error("unmapped read nonzero");
    a_status_width: assert property (rd_stb && !addr[5] && addr[2:0] == 3'h1 |=> rdata_r[31:2] == 30'h0) else $error("status bits wide");
    a_count_width: assert property (rd_stb && !addr[5] && addr[2:0] == 3'h2 |=> (rdata_r >> CW) == 32'h0) else $error("count too wide");
    a_result_read: assert property (rd_stb && addr == 6'h24 |=> rdata_r == $past(captured_motor_position_r)) else $error("result read");
    c_done: cover property ($fell(monitor_request_r));
    c_count_read: cover property (rd_stb && !addr[5] && addr[2:0] == 3'h2);
    c_tick_req: cover property (real_time_interrupt_tick && monitor_request_r);
endmodule
bind epc_core epc_core_chk #(.CW(CW)) i_chk (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_r(rdata_r), .real_time_interrupt_tick(real_time_interrupt_tick),
    .monitor_request_r(monitor_request_r), .captured_motor_position_r(captured_motor_position_r));
`default_nettype wire

// ==== epc_enc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================
// encoder counters; counts keep moving during captures
module epc_enc_model #(
    parameter NCH = 4,
    parameter CW = 24,
    parameter FW = 12
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic run,
    output logic [NCH*CW-1:0] enc_count,
    output logic [NCH*FW-1:0] enc_frac
);
    integer n;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            enc_count <= '0;
            enc_frac <= '0;
        end else if (run) begin
            for (n = 0; n < NCH; n = n + 1) begin
                enc_count[n*CW+:CW] <= enc_count[n*CW+:CW] + CW'(n * 77 + 1);
                enc_frac[n*FW+:FW] <= enc_frac[n*FW+:FW] + FW'(n * 5 + 301);
            end
        end
    end
endmodule
`default_nettype wire

// ==== epc_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================
// bench for the capture core
module epc_core_tb;
    logic mclk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, tick = 1'b0, run = 1'b0, hit, mon, gate, rnd;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0, d, off, res;
    logic [3:0] index_in = 4'h0, code;
    logic [15:0] flag_in = 16'h0;
    logic [95:0] enc_count;
    logic [47:0] enc_frac;
    logic [31:0] rdata_r;
    logic [23:0] cnt;
    logic [11:0] fr;
    logic [1:0] ch, src, sel;
    logic [4:0] rs, ls;
    logic req;
    logic [31:0] rdata_old, res_old, d_old;
    logic req_old, oh;
    integer fail_count = 0, n_tests = 0, i, k;
    always #10 mclk = ~mclk;
    epc_enc_model i_enc (.mclk(mclk), .nrst(nrst), .run(run), .enc_count(enc_count), .enc_frac(enc_frac));
    epc_core i_dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata_r(rdata_r), .enc_count(enc_count), .enc_frac(enc_frac), .index_in(index_in), .flag_in(flag_in),
        .real_time_interrupt_tick(tick), .monitor_request_r(req), .captured_motor_position_r(res));
    // older variant beside it: level capture, own-channel flags only
    epc_core #(.NEW_VARIANT(0)) i_dut_old (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata_r(rdata_old), .enc_count(enc_count), .enc_frac(enc_frac), .index_in(index_in),
        .flag_in(flag_in), .real_time_interrupt_tick(tick), .monitor_request_r(req_old),
        .captured_motor_position_r(res_old));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task final_report;
        if (fail_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a; wdata <= v; wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task rd(input logic [5:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr <= a; rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 v = rdata_r;
        d_old = rdata_old;
    endtask
    task pulse;
        @(posedge mclk);
        tick <= 1'b1;
        @(posedge mclk);
        tick <= 1'b0;
        #1;
    endtask
    // drive used inputs onto (on=1) or away from their trigger levels
    task drive(input logic on);
        @(posedge mclk);
        if (code[0]) index_in[ch] <= ~(on ^ code[1]);
        if (code[2]) flag_in[{src, sel}] <= ~(on ^ code[3]);
    endtask
    function automatic logic [31:0] mon_exp(input logic [35:0] raw);
        logic [63:0] t;
        t = {28'h0, raw} << ls;
        if (rnd && rs != 5'h0) t = t + (64'h1 << (rs - 5'h1));
        t = t >> rs;
        return t[31:0] - off;
    endfunction
    initial begin
        d = $urandom(32'h6db28015);
        repeat (5) @(posedge mclk);
        nrst <= 1'b1; run <= 1'b1;
        for (i = 0; i < 4; i++) begin
            rd({1'b0, 2'(i), 3'h0}, d); check(d, 32'(i) << 6);
        end
        rd(6'h07, d); check(d, 32'h0);
        rd(6'h3F, d); check(d, 32'h0);
        wr(6'h24, 32'hFFFF); rd(6'h24, d); check(d, 32'h0);
        for (i = 0; i < 40; i++) begin
            // first pass walks every trigger code, incl. ones using no input
            code = (i < 16) ? 4'(i) : 4'($urandom);
            ch = 2'($urandom); src = 2'($urandom); sel = 2'($urandom); gate = 1'($urandom);
            hit = code[0] | code[2];
            // older part only sees the flag when the source is its own set
            oh = hit & (~code[2] | (src == ch));
            mon = i[0] & hit;
            @(posedge mclk);
            index_in <= code[1] ? 4'h0 : 4'hF;
            flag_in <= code[3] ? 16'h0 : 16'hFFFF;
            wr({1'b0, ch, 3'h0}, {22'h0, 1'b1, gate, src, sel, code});
            rd({1'b0, ch, 3'h2}, d);
            rd({1'b0, ch, 3'h1}, d); check(d, 32'h0);
            if (mon) begin
                rs = 5'($urandom % 9); ls = 5'($urandom % 9); rnd = 1'($urandom); off = $urandom;
                wr(6'h21, {26'h0, 2'h1, 2'h0, ch});
                wr(6'h22, {15'h0, rnd, 3'h0, ls, 3'h0, rs});
                wr(6'h23, off);
                wr(6'h20, 32'h1); // no triggered move pending here
                pulse; pulse; check({31'h0, req}, 32'h1);
            end
            drive(1'b1);
            // settled counter value that the next edge latches
            #1;
            cnt = enc_count[ch*24+:24];
            fr = enc_frac[ch*12+:12];
            @(posedge mclk);
            if (mon) begin
                for (k = 0; k < 20 && req !== 1'b0; k++) pulse;
                check({31'h0, req}, 32'h0);
                if (k == 20) break;
                check(res, mon_exp({cnt, fr}));
                rd({1'b0, ch, 3'h1}, d); check(d, 32'h0);
            end else begin
                rd({1'b0, ch, 3'h1}, d); check(d, {30'h0, hit, hit & code[0] & gate});
                check(d_old, {30'h0, oh, oh & code[0] & gate});
                if (hit) begin
                    rd({1'b0, ch, 3'h3}, d); check(d, {20'h0, fr});
                    if (oh) check(d_old, {20'h0, fr});
                    rd({1'b0, ch, 3'h2}, d); check(d, {8'h0, cnt});
                    if (oh) check(d_old, {8'h0, cnt});
                    rd({1'b0, ch, 3'h1}, d); check(d, 32'h0);
                    check(d_old, {30'h0, oh, oh & code[0] & gate});
                    drive(1'b0); drive(1'b1); @(posedge mclk);
                    rd({1'b0, ch, 3'h1}, d); check(d, {30'h0, 1'b1, code[0] & gate});
                end
            end
        end
        final_report;
    end
endmodule
`default_nettype wire
